// ### rtl/disc_char_channel_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "disc_char_channel_defines.svh"

module disc_char_channel_port
    import disc_char_channel_pkg::*;
#(
    parameter int CHAR_W    = 6,   // bits per character
    parameter int CHARS_PW  = 4    // characters per assembled word
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    input  wire logic        xfer_clk,
    input  wire logic        in_char_bit1_n,
    input  wire logic        in_char_bit2_n,
    input  wire logic        in_char_bit3_n,
    input  wire logic        in_char_bit4_n,
    input  wire logic        in_char_bit5_n,
    input  wire logic        in_char_lsb_n,
    input  wire logic        in_parity_n,
    input  wire logic        halt_n,
    input  wire logic        test_n,
    input  wire logic        error_n,
    output var  logic        buffer_ctrl_strobe,
    output var  logic        interlace_active,
    output var  logic        halt_interlock,
    output var  logic        xfer_pending_ff,
    output var  logic        clock_seen_ff,
    output var  logic        cycle_phase_timing,
    output var  logic        io_mode_strobe,
    output var  logic        unit_dir_out,
    output var  logic        unit_sel_bit1,
    output var  logic        unit_sel_bit2,
    output var  logic        unit_sel_bit3,
    output var  logic        unit_sel_bit4,
    output var  logic        unit_sel_bit5
);

    localparam int WORD_W = CHAR_W * CHARS_PW;  // assembled word width
    localparam int CNT_W  = $clog2(CHARS_PW + 1);

    // true when a phase lies in the wrapping t6..t3 window
    function automatic logic phase_on(input logic [2:0] p);
        return (p >= `PHASE_ON_FIRST) || (p <= `PHASE_ON_LAST);
    endfunction : phase_on

    // ---------------- link domain (transfer clock) ----------------
    logic     [1:0]  lrst_sync;  // reset carried into link domain
    in_char_t        link_char;  // character held until next clock
    logic            link_tog;   // flips once per rising transfer clock edge
    wire             lrst = lrst_sync[1];

    // bench keeps the transfer clock running while rst is high
    always_ff @(posedge xfer_clk) begin
        lrst_sync <= {lrst_sync[0], rst};
    end

    // capture on the rising edge; lines inverted to true levels
    always_ff @(posedge xfer_clk) begin
        if (lrst) begin
            link_char <= '0;
            link_tog  <= 1'b0;
        end else begin
            link_char <= ~{in_char_bit1_n, in_char_bit2_n, in_char_bit3_n,
                           in_char_bit4_n, in_char_bit5_n, in_char_lsb_n,
                           in_parity_n};
            link_tog  <= ~link_tog;
        end
    end

    // ---------------- system domain ----------------
    logic [2:0]  tog_sync;   // [0],[1] synchroniser, [2] last seen
    logic [2:0]  pin_s1;     // first stage, read only by pin_s2
    logic [2:0]  pin_s2;     // synchronised halt, test, error (low true)
    ctrl_t       ctrl;       // software control register
    xfer_state_t state;      // character move sequence
    in_char_t    char_reg;   // character register
    logic [WORD_W-1:0] word_acc;   // word assembly register
    logic [WORD_W-1:0] word_out;   // last complete word for software
    logic [CNT_W-1:0]  char_cnt;   // characters in word_acc
    logic [2:0]  phase;      // computer cycle phase t0..t7
    logic        halted;     // sticky: halt ended a transfer
    logic        err_flag;   // sticky: error line grounded
    logic        skip_flag;  // last unit test result
    logic        word_rdy;   // sticky: word_out holds a new word
    logic        par_err;    // sticky: a character had even parity

    // synchronisers for the link event and the level pins
    always_ff @(posedge clk_sys) begin
        tog_sync <= {tog_sync[1], tog_sync[0], link_tog};
        pin_s1   <= {error_n, test_n, halt_n};
        pin_s2   <= pin_s1;
    end

    // decode of bus and link events
    wire req        = read | write;
    wire take       = req & ~waitrequest;  // the edge where access lands
    wire wr_ctrl    = take & write & (address == `CHAN_ADDR_CTRL);
    wire wr_cmd     = take & write & (address == `CHAN_ADDR_CMD);
    wire wr_status  = take & write & (address == `CHAN_ADDR_STATUS);
    wire rd_word    = take & read  & (address == `CHAN_ADDR_WORD);
    wire halt_req   = ~pin_s2[`PIN_HALT];
    wire test_low   = ~pin_s2[`PIN_TEST];
    wire err_low    = ~pin_s2[`PIN_ERR];
    wire link_ev    = (tog_sync[1] != tog_sync[2]);
    // events outside idle are dropped; the peripheral holds off then
    wire take_char  = link_ev & ctrl.ilv & (state == ST_IDLE);
    wire move_done  = (state == ST_MOVE);
    wire assemble   = move_done & ~ctrl.dir;
    wire word_full  = assemble && (char_cnt == CNT_W'(CHARS_PW - 1));
    wire start      = wr_ctrl & writedata[`CTRL_ILV_BIT] & ~ctrl.ilv;
    wire [2:0] next_phase = (phase == `PHASE_LAST) ? 3'h0 : phase + 3'h1;
    wire [WORD_W-1:0] next_word =
        {word_acc[WORD_W-CHAR_W-1:0], char_reg.bits};

    // status image and read mux
    wire [7:0] status_img = {par_err, word_rdy, skip_flag, err_flag,
                             halted, halt_interlock, xfer_pending_ff,
                             clock_seen_ff};
    wire [31:0] rd_mux =
        (address == `CHAN_ADDR_CTRL)   ? {25'h000_0000, ctrl} :
        (address == `CHAN_ADDR_STATUS) ? {24'h00_0000, status_img} :
        (address == `CHAN_ADDR_WORD)   ? 32'(word_out) :
                                         32'h0000_0000;  // cmd, unmapped

    // avalon handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= ~(req & waitrequest);
            if (read & waitrequest) begin
                readdata <= rd_mux;
            end
        end
    end

    // control register; a halt drops the interlace bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= writedata[`CTRL_ILV_BIT:0];
        end else if (halt_req) begin
            ctrl.ilv <= 1'b0;
        end
    end

    // unit address and interlace outputs straight from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interlace_active <= 1'b0;
            unit_dir_out     <= 1'b0;
            {unit_sel_bit1, unit_sel_bit2, unit_sel_bit3,
             unit_sel_bit4, unit_sel_bit5} <= 5'h00;
        end else begin
            interlace_active <= ctrl.ilv;
            unit_dir_out     <= ctrl.dir;
            {unit_sel_bit1, unit_sel_bit2, unit_sel_bit3,
             unit_sel_bit4, unit_sel_bit5} <= ctrl.sel;
        end
    end

    // one-cycle command strobes and the unit test sample
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buffer_ctrl_strobe <= 1'b0;
            io_mode_strobe     <= 1'b0;
            skip_flag          <= 1'b0;
        end else begin
            buffer_ctrl_strobe <= wr_cmd & writedata[`CMD_BUC_BIT];
            io_mode_strobe     <= wr_cmd & writedata[`CMD_IOC_BIT];
            if (wr_cmd & writedata[`CMD_SKS_BIT]) begin
                skip_flag <= test_low;
            end
        end
    end

    // computer cycle phase counter and timing output
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase              <= 3'h0;
            // phase 0 lies inside the window, so the output starts true
            cycle_phase_timing <= 1'b1;
        end else begin
            phase              <= next_phase;
            cycle_phase_timing <= phase_on(next_phase);
        end
    end

    // seen and pending set together, seen drops, then move into the word assembly register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state           <= ST_IDLE;
            clock_seen_ff   <= 1'b0;
            xfer_pending_ff <= 1'b0;
            char_reg        <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take_char) begin
                        state           <= ST_SEEN;
                        clock_seen_ff   <= 1'b1;
                        xfer_pending_ff <= 1'b1;
                        char_reg        <= link_char;
                    end
                end
                ST_SEEN: begin
                    state         <= ST_MOVE;
                    clock_seen_ff <= 1'b0;
                end
                ST_MOVE: begin
                    state           <= ST_IDLE;
                    xfer_pending_ff <= 1'b0;
                end
            endcase
        end
    end

    // word assembly; a new start clears the partial word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_acc <= '0;
            word_out <= '0;
            char_cnt <= '0;
        end else if (start) begin
            word_acc <= '0;
            char_cnt <= '0;
        end else if (assemble) begin
            word_acc <= next_word;
            char_cnt <= word_full ? '0 : char_cnt + CNT_W'(1);
            if (word_full) begin
                word_out <= next_word;
            end
        end
    end

    // sticky flags; a new event wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            halt_interlock <= 1'b0;
            halted         <= 1'b0;
            err_flag       <= 1'b0;
            word_rdy       <= 1'b0;
            par_err        <= 1'b0;
        end else begin
            if (move_done) begin
                halt_interlock <= 1'b1;
            end else if (start) begin
                halt_interlock <= 1'b0;
            end
            if (halt_req & ctrl.ilv) begin
                halted <= 1'b1;
            end else if (wr_status & writedata[`ST_HALT_BIT]) begin
                halted <= 1'b0;
            end
            if (err_low) begin
                err_flag <= 1'b1;
            end else if (wr_status & writedata[`ST_ERR_BIT]) begin
                err_flag <= 1'b0;
            end
            if (word_full) begin
                word_rdy <= 1'b1;
            end else if (rd_word) begin
                word_rdy <= 1'b0;
            end
            if (take_char & ~(^link_char)) begin
                par_err <= 1'b1;
            end else if (wr_status & writedata[`ST_PERR_BIT]) begin
                par_err <= 1'b0;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_seen;
        clock_seen_ff & xfer_pending_ff;
    endsequence
    sequence s_move;
        ~clock_seen_ff & xfer_pending_ff ##1 ~clock_seen_ff & ~xfer_pending_ff;
    endsequence

    chk_seen_then_move: assert property (
        take_char |=> s_seen ##1 s_move)
        else $error("seen/pending sequence broken");
    chk_pending_span: assert property (
        $rose(xfer_pending_ff) |-> xfer_pending_ff [*2] ##1 !xfer_pending_ff)
        else $error("pending not held two cycles");
    chk_lsb_place: assert property (
        assemble |=> word_acc[0] == $past(char_reg.bits[0]))
        else $error("lsb line not in word bit 0");
    chk_buc_strobe: assert property (
        (wr_cmd & writedata[`CMD_BUC_BIT]) |=> buffer_ctrl_strobe
            ##1 !buffer_ctrl_strobe)
        else $error("buffer control strobe wrong");
    chk_ioc_strobe: assert property (
        (wr_cmd & writedata[`CMD_IOC_BIT]) |=> io_mode_strobe
            ##1 !io_mode_strobe)
        else $error("io mode strobe wrong");
    chk_timing_window: assert property (
        $changed(cycle_phase_timing) |-> (cycle_phase_timing ?
            (phase == `PHASE_ON_FIRST) : (phase == `PHASE_ON_LAST + 3'h1)))
        else $error("timing output edge not at t6 or t4");
    chk_halt_stops: assert property (
        (halt_req & ~wr_ctrl) |=> !ctrl.ilv ##1 !interlace_active)
        else $error("halt did not end interlace");
    chk_error_flag: assert property (
        err_low |=> err_flag)
        else $error("grounded error line not flagged");
    chk_skip_result: assert property (
        (wr_cmd & writedata[`CMD_SKS_BIT]) |=> skip_flag == $past(test_low))
        else $error("skip result wrong");
    chk_dir_follows: assert property (
        wr_ctrl |=> ##1 unit_dir_out == $past(writedata[`CTRL_DIR_BIT], 2))
        else $error("direction output wrong");
    chk_interlock_set: assert property (
        move_done |=> halt_interlock)
        else $error("halt interlock not set");

endmodule : disc_char_channel_port

`default_nettype wire

// ### rtl/disc_char_channel_defines.svh
`ifndef DISC_CHAR_CHANNEL_DEFINES_SVH
`define DISC_CHAR_CHANNEL_DEFINES_SVH

// register byte addresses on the avalon slave
`define CHAN_ADDR_CTRL    4'h0
`define CHAN_ADDR_CMD     4'h4
`define CHAN_ADDR_STATUS  4'h8
`define CHAN_ADDR_WORD    4'hC

// control register fields and reset value
`define CTRL_SEL_LSB      0
`define CTRL_SEL_MSB      4
`define CTRL_DIR_BIT      5
`define CTRL_ILV_BIT      6
`define CTRL_RESET        7'h00

// command register bits (write only, self clearing)
`define CMD_BUC_BIT       0
`define CMD_IOC_BIT       1
`define CMD_SKS_BIT       2

// status register bits
`define ST_SEEN_BIT       0
`define ST_PEND_BIT       1
`define ST_HILK_BIT       2
`define ST_HALT_BIT       3
`define ST_ERR_BIT        4
`define ST_SKIP_BIT       5
`define ST_WRDY_BIT       6
`define ST_PERR_BIT       7

// computer cycle phases: t0..t7, timing output true t6 through t3
`define PHASE_LAST        3'h7
`define PHASE_ON_FIRST    3'h6
`define PHASE_ON_LAST     3'h3

// pin synchroniser lanes
`define PIN_HALT          0
`define PIN_TEST          1
`define PIN_ERR           2

`endif

// ### rtl/disc_char_channel_pkg.sv
package disc_char_channel_pkg;

    // one character as captured at the link, true levels
    typedef struct packed {
        logic [5:0] bits;    // bit 5 = first line, bit 0 = lsb line
        logic       parity;  // odd parity bit
    } in_char_t;

    // software control register
    typedef struct packed {
        logic       ilv;     // interlace active
        logic       dir;     // 1 = output, 0 = input
        logic [4:0] sel;     // unit select bits 1..5
    } ctrl_t;

    // character move sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEEN = 3'b010,
        ST_MOVE = 3'b100
    } xfer_state_t;

endpackage : disc_char_channel_pkg

// ### bench/disc_peripheral_model.sv
`timescale 1ns/100ps
`default_nettype none

// behavioural drum or disc unit controller: drives the character lines
// and the transfer clock, interlocked on the channel's handshake flops
module disc_peripheral_model (
    input  wire logic       run_free,         // free clock, reset only
    input  wire logic       clock_seen_ff,    // channel saw our clock
    input  wire logic       xfer_pending_ff,  // channel still moving
    output var  logic       xfer_clk,         // transfer clock to channel
    output var  logic [5:0] char_n,           // [5] first line, [0] lsb
    output var  logic       parity_n          // inverted odd parity
);
    // idle lines sit at the inactive (high) level
    initial begin
        xfer_clk = 1'b0;
        char_n   = 6'h3f;
        parity_n = 1'b1;
    end

    // the link side needs edges to leave reset; stands still otherwise
    always begin
        #3;
        if (run_free) begin
            xfer_clk = ~xfer_clk;
        end
    end

    // one character: wait for the flops to clear, low then high edge
    task automatic send_char(input logic [5:0] c);
        wait (!clock_seen_ff && !xfer_pending_ff);
        xfer_clk = 1'b0;
        char_n   = ~c;
        parity_n = ^c;
        #3 xfer_clk = 1'b1;
        #3 xfer_clk = 1'b0;
        // data stays until the next edge; wait until the clock is taken
        wait (clock_seen_ff);
    endtask : send_char
endmodule : disc_peripheral_model

`default_nettype wire

// ### bench/test_disc_char_channel_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "disc_char_channel_defines.svh"

module test_disc_char_channel_port;
    import disc_char_channel_pkg::*;

    // expected read value with the bits that matter
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } note_t;

    logic        clk_sys   = 1'b0;           // 50 MHz system clock
    logic        rst       = 1'b1;           // synchronous reset
    logic [3:0]  address   = 4'h0;           // avalon master signals
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic        halt_n    = 1'b1;           // far side control levels
    logic        test_n    = 1'b1;
    logic        error_n   = 1'b1;
    logic        run_free  = 1'b1;
    logic [31:0] seed      = 32'h0000_1b22;  // xorshift state
    logic [31:0] bad_count = 32'h0000_0000;
    logic [31:0] checks_done = 32'h0000_0000;
    logic [31:0] n_buc = 32'h0000_0000;      // strobe cycles seen
    logic [31:0] n_ioc = 32'h0000_0000;
    logic [31:0] n_hi  = 32'h0000_0000;      // timing output high cycles
    logic [31:0] n_seen = 32'h0000_0000;     // rises of seen / pending
    logic [31:0] n_pend = 32'h0000_0000;
    logic        seen_d = 1'b0;
    logic        pend_d = 1'b0;
    logic [31:0] cyc = 32'h0000_0000;        // timeout counter
    logic [31:0] v;
    logic [31:0] h0;
    logic [5:0]  c [4];
    note_t       notes [$];                  // pending read expectations
    wire  [31:0] readdata;
    wire         waitrequest;
    wire         xfer_clk;
    wire  [5:0]  line_n;
    wire         parity_n;
    wire         buffer_ctrl_strobe;
    wire         interlace_active;
    wire         halt_interlock;
    wire         xfer_pending_ff;
    wire         clock_seen_ff;
    wire         cycle_phase_timing;
    wire         io_mode_strobe;
    wire  [5:0]  unit_pins;                  // [5] direction, [4:0] select

    always #10 clk_sys = ~clk_sys;

    disc_char_channel_port u_dut (
        .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .xfer_clk(xfer_clk),
        .in_char_bit1_n(line_n[5]), .in_char_bit2_n(line_n[4]),
        .in_char_bit3_n(line_n[3]), .in_char_bit4_n(line_n[2]),
        .in_char_bit5_n(line_n[1]), .in_char_lsb_n(line_n[0]),
        .in_parity_n(parity_n), .halt_n(halt_n), .test_n(test_n),
        .error_n(error_n), .buffer_ctrl_strobe(buffer_ctrl_strobe),
        .interlace_active(interlace_active),
        .halt_interlock(halt_interlock),
        .xfer_pending_ff(xfer_pending_ff), .clock_seen_ff(clock_seen_ff),
        .cycle_phase_timing(cycle_phase_timing),
        .io_mode_strobe(io_mode_strobe), .unit_dir_out(unit_pins[5]),
        .unit_sel_bit1(unit_pins[4]), .unit_sel_bit2(unit_pins[3]),
        .unit_sel_bit3(unit_pins[2]), .unit_sel_bit4(unit_pins[1]),
        .unit_sel_bit5(unit_pins[0]));

    disc_peripheral_model u_per (
        .run_free(run_free), .clock_seen_ff(clock_seen_ff),
        .xfer_pending_ff(xfer_pending_ff), .xfer_clk(xfer_clk),
        .char_n(line_n), .parity_n(parity_n));

    // xorshift source for stimulus values
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // single comparison, counted; unknowns never match
    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    // one avalon access, held until waitrequest is sampled low
    task automatic av_cycle(input logic [3:0] a, input logic rd,
                            input logic [31:0] d);
        @(posedge clk_sys);
        address   <= a;
        read      <= rd;
        write     <= !rd;
        writedata <= d;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
    endtask : av_cycle

    task automatic av_write(input logic [3:0] a, input logic [31:0] d);
        av_cycle(a, 1'b0, d);
    endtask : av_write

    // the expectation goes on the queue before the request starts
    task automatic av_read(input logic [3:0] a, input logic [31:0] e,
                           input logic [31:0] m);
        notes.push_back('{exp: e, mask: m});
        av_cycle(a, 1'b1, 32'h0000_0000);
    endtask : av_read

    // read watcher: oldest note against data taken at the accept edge
    always @(posedge clk_sys) begin
        if (read && waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                chk_val("unexpected read", 32'h0000_0000, 32'hffff_ffff);
            end else begin
                chk_val("readdata", notes[0].exp,
                        readdata & notes[0].mask);
                void'(notes.pop_front());
            end
        end
    end

    // pin watchers; non-blocking so the main process reads stable counts
    always @(posedge clk_sys) begin
        seen_d <= clock_seen_ff;
        pend_d <= xfer_pending_ff;
        cyc    <= cyc + 1;
        if (!rst) begin
            n_buc <= n_buc + buffer_ctrl_strobe;
            n_ioc <= n_ioc + io_mode_strobe;
            n_hi  <= n_hi + cycle_phase_timing;
            n_seen <= n_seen + (clock_seen_ff && !seen_d);
            n_pend <= n_pend + (xfer_pending_ff && !pend_d);
        end
        if (cyc == 32'h0000_4e20) begin
            bad_count = bad_count + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst      <= 1'b0;
        // the link reset leaves over two transfer clock edges; keep them
        repeat (4) @(posedge clk_sys);
        run_free <= 1'b0;
        av_read(`CHAN_ADDR_CTRL, 32'h0000_0000, 32'hffff_ffff);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0000, 32'h0000_00ff);
        // direction and unit select pins follow the control register
        for (int i = 0; i < 4; i++) begin
            v = rnd() & 32'h0000_003f;
            av_write(`CHAN_ADDR_CTRL, v);
            repeat (2) @(posedge clk_sys);
            chk_val("unit pins", v[5:0],
                    {26'h0, unit_pins});
            av_read(`CHAN_ADDR_CTRL, v, 32'h0000_007f);
        end
        // back-to-back commands, one strobe each
        av_write(`CHAN_ADDR_CMD, 32'h0000_0001);
        av_write(`CHAN_ADDR_CMD, 32'h0000_0002);
        av_write(`CHAN_ADDR_CMD, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk_val("buffer strobes", 32'h0000_0002, n_buc);
        chk_val("io strobes", 32'h0000_0001, n_ioc);
        // six high phases in every eight-cycle computer cycle
        h0 = n_hi;
        repeat (80) @(posedge clk_sys);
        chk_val("timing high", 32'h0000_003c, n_hi - h0);
        // input word: four random characters, first in the top bits
        av_write(`CHAN_ADDR_CTRL, 32'h0000_0040);
        repeat (2) @(posedge clk_sys);
        chk_val("interlace", 32'h0000_0001,
                {31'h0, interlace_active});
        for (int i = 0; i < 4; i++) begin
            v    = rnd();
            c[i] = v[5:0];
            u_per.send_char(c[i]);
        end
        repeat (6) @(posedge clk_sys);
        chk_val("seen rises", 32'h0000_0004, n_seen);
        chk_val("pending rises", 32'h0000_0004, n_pend);
        chk_val("halt interlock", 32'h0000_0001,
                {31'h0, halt_interlock});
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0044,
                32'h0000_00c7);
        av_read(`CHAN_ADDR_WORD, {8'h00, c[0], c[1], c[2], c[3]},
                32'hffff_ffff);
        // unit test skip, both answers
        test_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        av_write(`CHAN_ADDR_CMD, 32'h0000_0004);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
        test_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        av_write(`CHAN_ADDR_CMD, 32'h0000_0004);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0000, 32'h0000_0020);
        // grounded error line is sticky until cleared after release
        error_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        error_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        av_write(`CHAN_ADDR_STATUS, 32'h0000_0010);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0000, 32'h0000_0010);
        // halt ends the interlace within a few cycles
        halt_n <= 1'b0;
        for (int i = 0; i < 8 && interlace_active !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        chk_val("halted interlace", 32'h0000_0000,
                {31'h0, interlace_active});
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
        av_read(`CHAN_ADDR_CTRL, 32'h0000_0000, 32'h0000_0040);
        halt_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        av_write(`CHAN_ADDR_STATUS, 32'h0000_0008);
        av_read(`CHAN_ADDR_STATUS, 32'h0000_0000, 32'h0000_0008);
        repeat (4) @(posedge clk_sys);
        chk_val("notes left", 32'h0000_0000, notes.size());
        wrap_up();
    end
endmodule : test_disc_char_channel_port

`default_nettype wire
